// File: bench/fsm_checker.sv
// Port assertions for the fan monitor
module fsm_checker (
	input wire mclk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire [31:0] prdata,
	input wire fanTach,
	input wire sleepReq,
	input wire sleepAck,
	input wire fanIrq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire mapped = paddr <= 12'h00C && paddr[1:0] == 2'b00;
	sequence acc;
		psel && penable;
	endsequence
	sequence accBad;
		psel && penable && !mapped;
	endsequence
	chk_ack_delay: assert property (1 |=> sleepAck == $past(sleepReq))
		else $error("sleep ack late");
	chk_bad_addr: assert property (accBad |-> pslverr)
		else $error("no error on unmapped");
	chk_good_addr: assert property (acc ##0 mapped |-> !pslverr)
		else $error("error on mapped");
	chk_bad_zero: assert property (accBad ##0 !pwrite |-> prdata == 0)
		else $error("unmapped read not zero");
	chk_rd_hold: assert property (acc |=> $stable(prdata))
		else $error("read data moved");
	chk_irq_drop: assert property ($fell(fanIrq) |->
		$past(psel && pwrite && paddr <= 12'h004) || $past(sleepReq))
		else $error("irq fell alone");
	chk_rst_quiet: assert property ($rose(nrst) |-> !fanIrq && !sleepAck)
		else $error("outputs busy after reset");
	chk_sleep_quiet: assert property (sleepAck && $past(sleepAck) &&
		!$past(psel) |-> !$rose(fanIrq))
		else $error("irq rose in sleep");
endmodule // fsm_checker
bind fsm_fan_speed_monitor fsm_checker u_chk (.mclk(mclk), .nrst(nrst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.fanTach(fanTach), .sleepReq(sleepReq), .sleepAck(sleepAck),
	.fanIrq(fanIrq));

// File: bench/fsm_fan_model.sv
// Fan tach source: square wave while run is high
module fsm_fan_model (
	input wire run,
	input wire [15:0] halfNs,
	output logic fanTach,
	output int rises
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		fanTach = 0;
		rises = 0;
		forever begin
			wait (run === 1'b1);
			#(halfNs) fanTach = 1;
			rises++;
			#(halfNs) fanTach = 0;
		end
	end
endmodule // fsm_fan_model

// File: bench/fsm_fan_speed_monitor_tb.sv
// Fan monitor bench with a fan model
module fsm_fan_speed_monitor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic run = 0, sleepReq = 0;
	logic [11:0] paddr = 0;
	logic [15:0] hp = 100;
	logic [31:0] pwdata = 0, rd, r0, seed = 32'h32BC96D5;
	logic [31:0] rstv[5] = '{0, 0, 32'hFFFF, 0, 0};
	int edges[4] = '{2, 3, 5, 9};
	int fails = 0, checked = 0, k, m0, rises;
	wire pready, pslverr, sleepAck, fanIrq, fanTach;
	wire [31:0] prdata;
	fsm_fan_speed_monitor u_dut (.mclk(mclk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .fanTach(fanTach),
		.sleepReq(sleepReq), .sleepAck(sleepAck), .fanIrq(fanIrq));
	fsm_fan_model u_fan (.run(run), .halfNs(hp), .fanTach(fanTach),
		.rises(rises));
	initial forever #2 mclk = ~mclk;
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task end_of_test();
		$display("fails %0d checked %0d", fails, checked);
		if (fails == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task hang();
		fails++;
		end_of_test();
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp, input int tol);
		checked++;
		if ((got - exp + tol <= 2 * tol) !== 1'b1) begin
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
			fails++;
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		for (k = 0; k < 9; k++) begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 9)
			hang();
		rd = prdata;
		cmp(pslverr, a > 12'h00C, 0);
		psel <= 0;
		penable <= 0;
	endtask
	task waitRdy();
		for (int j = 0; j < 9000; j++) begin
			apb(0, 12'h004, 0);
			if (rd[3] === 1'b1)
				return;
		end
		hang();
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		nrst <= 1;
		for (int i = 0; i < 5; i++) begin
			apb(0, 12'(i * 4), 0);
			cmp(rd, rstv[i], 0);
		end
		r0 = rnd();
		apb(1, 12'h00C, r0);
		apb(0, 12'h00C, 0);
		cmp(rd, r0 & 32'hFFFF, 0);
		apb(1, 12'h00C, 0);
		$display("test registers done");
		apb(1, 12'h000, 32'h1);
		for (int s = 0; s < 2; s++) begin
			sleepReq <= s[0];
			apb(0, 12'h000, 0);
			r0 = rd;
			m0 = rises;
			hp <= 16'(60 + rnd() % 40);
			run <= 1;
			repeat (300) @(posedge mclk);
			run <= 0;
			repeat (80) @(posedge mclk);
			apb(0, 12'h000, 0);
			cmp(sleepAck, s, 0);
			k = s ? 0 : rises - m0;
			cmp(16'(rd[31:16] - r0[31:16]), 16'(k), 0);
		end
		sleepReq <= 0;
		apb(0, 12'h004, 0);
		cmp(rd[2:1], 32'h1, 0);
		$display("test free count done");
		hp <= 16'd6000;
		run <= 1;
		for (int e = 0; e < 4; e++) begin
			apb(1, 12'h000, 32'h3 | e << 11);
			apb(1, 12'h004, 32'hF);
			waitRdy();
			apb(1, 12'h004, 32'h8);
			waitRdy();
			cmp(fanIrq, 0, 0);
			apb(0, 12'h000, 0);
			cmp(rd[31:16], ((edges[e] - 1) * 6 + 5) / 10, 1);
		end
		apb(1, 12'h000, 32'h5803);
		#1;
		cmp(fanIrq, 1, 0);
		$display("test interval done");
		apb(1, 12'h008, 0);
		apb(1, 12'h000, 32'h1803);
		apb(1, 12'h004, 32'hF);
		waitRdy();
		apb(0, 12'h004, 0);
		cmp(rd[0], 1, 0);
		cmp(fanIrq, 1, 0);
		apb(1, 12'h000, 0);
		apb(1, 12'h004, 32'hF);
		#1;
		cmp(fanIrq, 0, 0);
		$display("test limits done");
		end_of_test();
	end
endmodule // fsm_fan_speed_monitor_tb

// File: hdl/fsm_fan_speed_monitor.v
// Fan tachometer monitor with APB register slave
//
// Implementation choice: register access over APB.
`include "fsm_map.vh"
// Function
// - Mode bit selects free edge counting (0) or reference interval timing (1).
// - Mode 0 counts one per rising edge of the fan input.
// - Mode 0 counter wraps FFFFh to 0000h silently.
// - Mode 1 counts 100 kHz reference ticks over programmed edges.
// - Mode 1 latches reading and sets count-ready after programmed edges.
// - Count-ready with its enable set raises an interrupt event.
// - Reading above high limit or below low limit sets limit flag.
// - Limit flag set raises an interrupt event.
// - Interrupt output is OR of the limit flag (no enable) and the enabled ready and toggle events.
// - System reset returns all registers and logic to defaults.
// - Enable low or sleep stops monitoring.
// - Low-power request from power controller puts block to sleep.
// - Control 00h, status 04h, high limit 08h, low limit 0Ch.
// - Range covers fans from 100 to 30,000 RPM.
// - Edge field: 11b nine, 10b five, 01b three, 00b two edges.
// - Mode 1 latches at FFFFh too; counter clears after each copy.
module fsm_fan_speed_monitor (
	input wire mclk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output reg [31:0] prdata,
	input wire fanTach,
	input wire sleepReq,
	output wire sleepAck,
	output wire fanIrq
);
	reg enable;
	reg modeSel;
	reg [1:0] edgeSel;
	reg readyIntEn;
	reg toggleIntEn;
	reg [15:0] highLimit;
	reg [15:0] lowLimit;
	reg [15:0] pulseCount;
	reg [31:0] readMux;
	reg [15:0] speedReading;
	reg limitViolationFlag;
	reg toggleFlag;
	reg countReady;
	reg [11:0] refDiv;
	reg [3:0] edgeCount;
	reg armed;
	reg sleeping;
	wire tachLevel;
	wire tachRise;
	wire tachToggle;
	wire running;
	wire refTick;
	wire [3:0] edgesNeeded;
	wire apbWrite;
	wire apbRead;
	wire newReading;
	wire [15:0] nextReading;
	wire latchMode1;
	wire outOfRange;
	wire edgeDone;
	wire counterFull;

	function [3:0] edgeTarget;
		input [1:0] sel;
		begin
			case (sel)
				2'b11: edgeTarget = `FSM_EDGES_9;
				2'b10: edgeTarget = `FSM_EDGES_5;
				2'b01: edgeTarget = `FSM_EDGES_3;
				default: edgeTarget = `FSM_EDGES_2;
			endcase
		end
	endfunction

	function isAddr;
		input [11:0] a;
		input [11:0] b;
		begin
			isAddr = (a == b);
		end
	endfunction

	function statClear;
		input wr;
		input [11:0] a;
		input bitVal;
		begin
			statClear = wr & isAddr(a, `FSM_ADDR_STAT) & bitVal;
		end
	endfunction

	// Fan pin synchroniser
	fsm_sync_edge uSync (
		.mclk(mclk),
		.nrst(nrst),
		.pinIn(fanTach),
		.level(tachLevel),
		.rise(tachRise),
		.toggle(tachToggle)
	);

	// APB handshake, zero wait states
	assign pready = 1'b1;
	assign apbWrite = psel & penable & pwrite;
	assign apbRead = psel & ~pwrite;
	assign pslverr = psel & penable & ~(isAddr(paddr, `FSM_ADDR_CTRL) |
		isAddr(paddr, `FSM_ADDR_STAT) | isAddr(paddr, `FSM_ADDR_HIGH) |
		isAddr(paddr, `FSM_ADDR_LOW));
	assign running = enable & ~sleeping;
	assign sleepAck = sleeping;
	assign edgesNeeded = edgeTarget(edgeSel);
	assign refTick = (refDiv == `FSM_DIV_MAX);

	// Mode 1 finishes on programmed edges or on saturation
	assign edgeDone = tachToggle && (edgeCount + 4'h1 >= edgesNeeded);
	assign counterFull = (pulseCount == `FSM_CNT_MAX);
	assign latchMode1 = running & modeSel & armed &
		(edgeDone | counterFull);
	assign nextReading = modeSel ? pulseCount :
		(pulseCount + 16'h0001);
	assign newReading = latchMode1 |
		(running & ~modeSel & tachRise);
	assign outOfRange = (nextReading > highLimit) ||
		(nextReading < lowLimit);

	// Power controller sleep handshake
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sleeping <= 1'b0;
		end else begin
			sleeping <= sleepReq;
		end
	end

	// 100 kHz reference divider
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			refDiv <= 12'h000;
		end else if (!running || !modeSel || refTick) begin
			refDiv <= 12'h000;
		end else begin
			refDiv <= refDiv + 12'h001;
		end
	end

	// Pulse counter and edge tracking
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pulseCount <= `FSM_CNT_ZERO;
			edgeCount <= 4'h0;
			armed <= 1'b0;
		end else if (!running) begin
			edgeCount <= 4'h0;
			armed <= 1'b0;
			if (modeSel) begin
				pulseCount <= `FSM_CNT_ZERO;
			end
		end else if (!modeSel) begin
			armed <= 1'b0;
			edgeCount <= 4'h0;
			if (tachRise) begin
				pulseCount <= pulseCount + 16'h0001;
			end
		end else if (!armed) begin
			pulseCount <= `FSM_CNT_ZERO;
			edgeCount <= 4'h0;
			if (tachToggle) begin
				armed <= 1'b1;
				edgeCount <= 4'h1;
			end
		end else if (latchMode1) begin
			pulseCount <= `FSM_CNT_ZERO;
			edgeCount <= 4'h1;
		end else begin
			if (tachToggle) begin
				edgeCount <= edgeCount + 4'h1;
			end
			if (refTick) begin
				pulseCount <= pulseCount + 16'h0001;
			end
		end
	end

	// Latched reading
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			speedReading <= `FSM_CNT_ZERO;
		end else if (newReading) begin
			speedReading <= nextReading;
		end
	end

	// Limit flag, hardware set wins over clear
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			limitViolationFlag <= 1'b0;
		end else if (newReading && outOfRange) begin
			limitViolationFlag <= 1'b1;
		end else if (statClear(apbWrite, paddr, pwdata[`FSM_ST_LIMIT])) begin
			limitViolationFlag <= 1'b0;
		end
	end

	// Count ready flag, hardware set wins over clear
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			countReady <= 1'b0;
		end else if (latchMode1) begin
			countReady <= 1'b1;
		end else if (statClear(apbWrite, paddr, pwdata[`FSM_ST_READY])) begin
			countReady <= 1'b0;
		end
	end

	// Pin toggle flag, hardware set wins over clear
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			toggleFlag <= 1'b0;
		end else if (running && tachToggle) begin
			toggleFlag <= 1'b1;
		end else if (statClear(apbWrite, paddr, pwdata[`FSM_ST_TOGGLE])) begin
			toggleFlag <= 1'b0;
		end
	end

	// Control register
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			enable <= 1'b0;
			modeSel <= 1'b0;
			edgeSel <= 2'b00;
			readyIntEn <= 1'b0;
			toggleIntEn <= 1'b0;
		end else if (apbWrite && isAddr(paddr, `FSM_ADDR_CTRL)) begin
			enable <= pwdata[`FSM_BIT_ENABLE];
			modeSel <= pwdata[`FSM_BIT_MODE];
			edgeSel <= pwdata[`FSM_EDGE_HI:`FSM_EDGE_LO];
			readyIntEn <= pwdata[`FSM_BIT_RDYIE];
			toggleIntEn <= pwdata[`FSM_BIT_TOGIE];
		end
	end

	// Limit registers
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			highLimit <= `FSM_HIGH_RST;
			lowLimit <= `FSM_LOW_RST;
		end else if (apbWrite) begin
			if (isAddr(paddr, `FSM_ADDR_HIGH)) begin
				highLimit <= pwdata[15:0];
			end
			if (isAddr(paddr, `FSM_ADDR_LOW)) begin
				lowLimit <= pwdata[15:0];
			end
		end
	end

	// Read multiplexer
	always @* begin
		readMux = 32'h00000000;
		if (isAddr(paddr, `FSM_ADDR_CTRL)) begin
			readMux[31:`FSM_CNT_LO] = speedReading;
			readMux[`FSM_BIT_TOGIE] = toggleIntEn;
			readMux[`FSM_BIT_RDYIE] = readyIntEn;
			readMux[`FSM_EDGE_HI:`FSM_EDGE_LO] = edgeSel;
			readMux[`FSM_BIT_MODE] = modeSel;
			readMux[`FSM_BIT_ENABLE] = enable;
		end
		if (isAddr(paddr, `FSM_ADDR_STAT)) begin
			readMux[`FSM_ST_LIMIT] = limitViolationFlag;
			readMux[`FSM_ST_TOGGLE] = toggleFlag;
			readMux[`FSM_ST_PIN] = tachLevel;
			readMux[`FSM_ST_READY] = countReady;
		end
		if (isAddr(paddr, `FSM_ADDR_HIGH)) begin
			readMux[15:0] = highLimit;
		end
		if (isAddr(paddr, `FSM_ADDR_LOW)) begin
			readMux[15:0] = lowLimit;
		end
	end

	// Read data register, loaded in the setup phase
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h00000000;
		end else if (apbRead && !penable) begin
			prdata <= readMux;
		end
	end

	// Combined interrupt
	assign fanIrq = limitViolationFlag |
		(countReady & readyIntEn) |
		(toggleFlag & toggleIntEn);
endmodule // fsm_fan_speed_monitor

// File: hdl/fsm_map.vh
// Register map, field positions and timing constants of the fan monitor
`ifndef FSM_MAP_VH
`define FSM_MAP_VH
`define FSM_ADDR_CTRL 12'h000
`define FSM_ADDR_STAT 12'h004
`define FSM_ADDR_HIGH 12'h008
`define FSM_ADDR_LOW 12'h00C
`define FSM_BIT_ENABLE 0
`define FSM_BIT_MODE 1
`define FSM_EDGE_LO 11
`define FSM_EDGE_HI 12
`define FSM_BIT_RDYIE 14
`define FSM_BIT_TOGIE 15
`define FSM_CNT_LO 16
`define FSM_ST_LIMIT 0
`define FSM_ST_TOGGLE 1
`define FSM_ST_PIN 2
`define FSM_ST_READY 3
`define FSM_CLK_HZ 250000000
`define FSM_REF_HZ 100000
`define FSM_REF_DIV (`FSM_CLK_HZ / `FSM_REF_HZ)
`define FSM_DIV_MAX 12'h9C3
`define FSM_CNT_MAX 16'hFFFF
`define FSM_CNT_ZERO 16'h0000
`define FSM_HIGH_RST 16'hFFFF
`define FSM_LOW_RST 16'h0000
`define FSM_EDGES_2 4'h2
`define FSM_EDGES_3 4'h3
`define FSM_EDGES_5 4'h5
`define FSM_EDGES_9 4'h9
`endif

// File: hdl/fsm_sync_edge.v
// Two-stage input synchroniser with rising and any-edge detect
module fsm_sync_edge (
	input wire mclk,
	input wire nrst,
	input wire pinIn,
	output wire level,
	output wire rise,
	output wire toggle
);
	reg stage1;
	reg stage2;
	reg stage3;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end
	assign level = stage2;
	assign rise = stage2 & ~stage3;
	assign toggle = stage2 ^ stage3;
endmodule // fsm_sync_edge
